// ==== logic/wsg_gate_end.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// clock gating end: stretches bus cycles by stopping the 2x clock
// ----------------------------------------------------------------
module wsg_gate_end (
    // clock and reset (sys_clk is the 4x oscillator)
    input wire logic sys_clk,
    input wire logic resetn,
    // processor side
    wsg_bus_if.gate bus,
    // system wait logic
    input wire logic wait_req,
    // status
    output logic clk_held_r,
    output logic stretch_overrun_r,
    output logic [5:0] last_stretch_r
);

    // ----------------------------------------------------------------
    // gate states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        G_RUN = 2'b00,
        G_HELD = 2'b01,
        G_RESYNC = 2'b10,
        G_FORCED = 2'b11
    } wsg_gate_e;

    wsg_gate_e state_r;
    wsg_gate_e state_nxt;
    logic [1:0] phase_r;
    logic [1:0] phase_nxt;
    logic wait_meta_r;
    logic wait_sync_r;
    logic free2x_nxt;
    logic free1x_nxt;
    logic rise2x_nxt;
    logic align_nxt;
    logic open_nxt;
    logic limit_hit;
    logic [5:0] stop_cnt_r;
    logic clk2x_r;
    logic clk1x_r;
    logic ready_n_r;

    // ----------------------------------------------------------------
    // phase source
    // ----------------------------------------------------------------
    wsg_phase_div u_div (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .phase_r(phase_r),
        .phase_nxt(phase_nxt)
    );

    // 2x toggles every 4x edge, 1x every second one
    always_comb begin
        free2x_nxt = ~phase_nxt[0];
        free1x_nxt = ~phase_nxt[1];
        rise2x_nxt = free2x_nxt;
        align_nxt = (phase_nxt == wsg_pkg::PHASE_ALIGN);
    end

    // ----------------------------------------------------------------
    // wait request synchroniser
    // ----------------------------------------------------------------
    // the request comes from board logic on unrelated timing
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wait_meta_r <= 1'b0;
            wait_sync_r <= 1'b0;
        end else begin
            wait_meta_r <= wait_req;
            wait_sync_r <= wait_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // stop length limit
    // ----------------------------------------------------------------
    // dynamic storage in the processor decays; the limit wins over
    // the request and the clock runs again until the request drops
    always_comb begin
        limit_hit = (stop_cnt_r >= wsg_pkg::MAX_STOP_CYC - 6'h01);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stop_cnt_r <= wsg_pkg::STOP_CNT_ZERO;
        end else if (state_r == G_HELD || state_r == G_RESYNC) begin
            stop_cnt_r <= stop_cnt_r + wsg_pkg::STOP_CNT_ONE;
        end else begin
            stop_cnt_r <= wsg_pkg::STOP_CNT_ZERO;
        end
    end

    // ----------------------------------------------------------------
    // gate state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            G_RUN: begin
                // close only where the 2x clock would rise
                if (wait_sync_r && rise2x_nxt) begin
                    state_nxt = G_HELD;
                end
            end
            G_HELD: begin
                if (!wait_sync_r || limit_hit) begin
                    state_nxt = G_RESYNC;
                end
            end
            G_RESYNC: begin
                // reopen only on the shared rising edge of 1x and 2x
                if (align_nxt) begin
                    if (wait_sync_r) begin
                        state_nxt = G_FORCED;
                    end else begin
                        state_nxt = G_RUN;
                    end
                end
            end
            G_FORCED: begin
                if (!wait_sync_r) begin
                    state_nxt = G_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= G_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // clock outputs
    // ----------------------------------------------------------------
    always_comb begin
        open_nxt = (state_nxt == G_RUN) || (state_nxt == G_FORCED);
    end

    // held low while stopped: the last low phase only grows longer,
    // so the processor never sees a short pulse
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clk2x_r <= 1'b0;
            clk1x_r <= 1'b0;
        end else begin
            clk2x_r <= open_nxt ? free2x_nxt : 1'b0;
            clk1x_r <= free1x_nxt;
        end
    end

    // completion input tied active; waits come from the gate only
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ready_n_r <= 1'b0;
        end else begin
            ready_n_r <= 1'b0;
        end
    end

    assign bus.clk2x = clk2x_r;
    assign bus.clk1x = clk1x_r;
    assign bus.ready_n = ready_n_r;

    // ----------------------------------------------------------------
    // status
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clk_held_r <= 1'b0;
        end else begin
            clk_held_r <= !open_nxt;
        end
    end

    // one-cycle pulse when the limit forced a reopen
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stretch_overrun_r <= 1'b0;
        end else begin
            stretch_overrun_r <= (state_r == G_RESYNC)
                && (state_nxt == G_FORCED);
        end
    end

    // length of the most recent stop in 4x cycles
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            last_stretch_r <= wsg_pkg::STOP_CNT_ZERO;
        end else if (state_r == G_RESYNC && state_nxt != G_RESYNC) begin
            last_stretch_r <= stop_cnt_r + wsg_pkg::STOP_CNT_ONE;
        end
    end

endmodule // wsg_gate_end
`default_nettype wire

// ==== logic/wsg_pkg.sv ====
package wsg_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 40;
    localparam int MAX_STOP_NS = 1000;
    // longest time: rounds down
    localparam int MAX_STOP_CYC_I = MAX_STOP_NS / SYS_CLK_PERIOD_NS;
    localparam logic [5:0] MAX_STOP_CYC = 6'(MAX_STOP_CYC_I);
    localparam logic [5:0] STOP_CNT_ZERO = 6'h00;
    localparam logic [5:0] STOP_CNT_ONE = 6'h01;

    // ----------------------------------------------------------------
    // phase counter of the 4x oscillator
    // ----------------------------------------------------------------
    localparam logic [1:0] PHASE_ALIGN = 2'h0;
    localparam logic [1:0] PHASE_ONE = 2'h1;

    // ----------------------------------------------------------------
    // processor side access description
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        WSG_SZ_BYTE = 3'h0,
        WSG_SZ_SHORT = 3'h1,
        WSG_SZ_WORD = 3'h2,
        WSG_SZ_LONG = 3'h3,
        WSG_SZ_TRIPLE = 3'h4,
        WSG_SZ_QUAD = 3'h5
    } wsg_size_e;

    localparam logic [1:0] LANES_NONE_N = 2'h3;
    localparam logic [1:0] LANES_BOTH_N = 2'h0;
    localparam logic [1:0] LANES_LOW_N = 2'h2;
    localparam logic [1:0] LANES_HIGH_N = 2'h1;
    localparam logic [3:0] XFER_ONE = 4'h1;
    localparam logic [3:0] WS_ZERO = 4'h0;
    localparam logic [3:0] WS_ONE = 4'h1;

    // 16-bit data path: transfers per access, one extra if misaligned, except for a byte
    function automatic logic [3:0] wsg_xfers(input wsg_size_e sz,
                                             input logic mis);
        logic [3:0] n;
        n = 4'h1;
        unique case (sz)
            WSG_SZ_BYTE: n = 4'h1;
            WSG_SZ_SHORT: n = 4'h1;
            WSG_SZ_WORD: n = 4'h2;
            WSG_SZ_LONG: n = 4'h4;
            WSG_SZ_TRIPLE: n = 4'h6;
            WSG_SZ_QUAD: n = 4'h8;
            default: n = 4'h1;
        endcase
        if (mis && sz != WSG_SZ_BYTE) begin
            n = n + 4'h1;
        end
        return n;
    endfunction

endpackage

// ==== logic/wsg_bus_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface wsg_bus_if;
    logic clk2x;
    logic clk1x;
    logic ready_n;
    logic [1:0] byte_lane_select_n;
    logic bus_active;
    logic wait_state_cycle;

    modport gate (
        output clk2x,
        output clk1x,
        output ready_n
    );

    modport proc (
        input clk2x,
        input ready_n,
        output byte_lane_select_n,
        output bus_active,
        output wait_state_cycle
    );
endinterface
`default_nettype wire

// ==== logic/wsg_phase_div.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// free running phase of the 4x oscillator
// ----------------------------------------------------------------
module wsg_phase_div (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // phase
    output logic [1:0] phase_r,
    output logic [1:0] phase_nxt
);
    // system clocks never stop, so this counter never holds
    always_comb begin
        phase_nxt = phase_r + wsg_pkg::PHASE_ONE;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            // one step before the shared rise: no short 1x pulse at start
            phase_r <= wsg_pkg::PHASE_ALIGN - wsg_pkg::PHASE_ONE;
        end else begin
            phase_r <= phase_nxt;
        end
    end
endmodule // wsg_phase_div
`default_nettype wire

// ==== logic/wsg_proc_end.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// processor bus end, with the early lane switch defect
// ----------------------------------------------------------------
module wsg_proc_end (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // clock and bus pins
    wsg_bus_if.proc bus,
    // access request
    input wire logic acc_req,
    input wire wsg_pkg::wsg_size_e acc_size,
    input wire logic acc_misaligned,
    input wire logic acc_byte_high,
    input wire logic defect_en,
    // access status
    output logic acc_busy_r,
    output logic acc_done_r
);

    // ----------------------------------------------------------------
    // bus states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        P_IDLE = 2'b00,
        P_ADDR = 2'b01,
        P_DATA = 2'b10
    } wsg_proc_e;

    wsg_proc_e state_r;
    logic clk2x_prev_r;
    logic step;
    logic affected_r;
    logic [3:0] xfer_left_r;
    logic [3:0] ws_cnt_r;
    logic [1:0] lanes_ok_r;
    logic [1:0] lanes_r;
    logic first_r;
    logic wait_r;
    logic [1:0] first_lanes;

    // the processor advances only on a rising 2x edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clk2x_prev_r <= 1'b0;
        end else begin
            clk2x_prev_r <= bus.clk2x;
        end
    end

    assign step = bus.clk2x & ~clk2x_prev_r;

    always_comb begin
        if (acc_size == wsg_pkg::WSG_SZ_BYTE) begin
            first_lanes = acc_byte_high ? wsg_pkg::LANES_HIGH_N
                                        : wsg_pkg::LANES_LOW_N;
        end else if (acc_misaligned) begin
            first_lanes = wsg_pkg::LANES_HIGH_N;
        end else begin
            first_lanes = wsg_pkg::LANES_BOTH_N;
        end
    end

    // ----------------------------------------------------------------
    // bus sequence
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= P_IDLE;
            affected_r <= 1'b0;
            xfer_left_r <= wsg_pkg::WS_ZERO;
            ws_cnt_r <= wsg_pkg::WS_ZERO;
            lanes_ok_r <= wsg_pkg::LANES_NONE_N;
            lanes_r <= wsg_pkg::LANES_NONE_N;
            first_r <= 1'b0;
            wait_r <= 1'b0;
            acc_busy_r <= 1'b0;
            acc_done_r <= 1'b0;
        end else begin
            acc_done_r <= 1'b0;
            if (step) begin
                unique case (state_r)
                    P_IDLE: begin
                        if (acc_req) begin
                            state_r <= P_ADDR;
                            acc_busy_r <= 1'b1;
                            xfer_left_r <= wsg_pkg::wsg_xfers(acc_size,
                                acc_misaligned);
                            affected_r <= (acc_size == wsg_pkg::WSG_SZ_BYTE)
                                || acc_misaligned;
                            lanes_ok_r <= first_lanes;
                            first_r <= 1'b1;
                        end
                    end
                    P_ADDR: begin
                        state_r <= P_DATA;
                        lanes_r <= lanes_ok_r;
                        ws_cnt_r <= wsg_pkg::WS_ZERO;
                        wait_r <= 1'b0;
                    end
                    P_DATA: begin
                        if (!bus.ready_n) begin
                            wait_r <= 1'b0;
                            ws_cnt_r <= wsg_pkg::WS_ZERO;
                            first_r <= 1'b0;
                            if (xfer_left_r == wsg_pkg::XFER_ONE) begin
                                state_r <= P_IDLE;
                                acc_busy_r <= 1'b0;
                                acc_done_r <= 1'b1;
                                lanes_r <= wsg_pkg::LANES_NONE_N;
                            end else begin
                                // next burst transfer restarts the lanes
                                xfer_left_r <= xfer_left_r - wsg_pkg::XFER_ONE;
                                lanes_r <= (affected_r && first_r
                                    && acc_size != wsg_pkg::WSG_SZ_BYTE)
                                    ? wsg_pkg::LANES_BOTH_N
                                    : lanes_r;
                                lanes_ok_r <= wsg_pkg::LANES_BOTH_N;
                            end
                        end else begin
                            wait_r <= 1'b1;
                            ws_cnt_r <= ws_cnt_r + wsg_pkg::WS_ONE;
                            // fault: lanes flip as the first wait state starts
                            if (defect_en && affected_r
                                && ws_cnt_r == wsg_pkg::WS_ZERO) begin
                                lanes_r <= ~lanes_r;
                            end
                        end
                    end
                    default: begin
                        state_r <= P_IDLE;
                    end
                endcase
            end
        end
    end

    // with no wait state the flip branch is never reached
    assign bus.byte_lane_select_n = lanes_r;
    assign bus.bus_active = acc_busy_r;
    assign bus.wait_state_cycle = wait_r;

endmodule // wsg_proc_end
`default_nettype wire

// ==== sim/wsg_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// link checker
// ----------------------------------------------------------------
module wsg_sva (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // link
    input wire logic clk2x,
    input wire logic clk1x,
    input wire logic ready_n,
    input wire logic [1:0] byte_lane_select_n,
    input wire logic bus_active,
    input wire logic wait_state_cycle
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    property p_ready_low;
        ready_n == 1'h0;
    endproperty
    a_ready_low: assert property (p_ready_low)
        else $error("completion input left the active level");

    property p_no_waits;
        !wait_state_cycle;
    endproperty
    a_no_waits: assert property (p_no_waits)
        else $error("wait state seen on the processor bus");

    property p_clk1x_period;
        $rose(clk1x) |-> ##1 clk1x ##1 !clk1x ##1 !clk1x ##1 clk1x;
    endproperty
    a_clk1x_period: assert property (p_clk1x_period)
        else $error("system clock is not a quarter of the oscillator");

    property p_rise_aligned;
        $rose(clk2x) && !$past(clk2x, 2) |-> $rose(clk1x);
    endproperty
    a_rise_aligned: assert property (p_rise_aligned)
        else $error("2x clock rose off the system clock phase");

    property p_high_one;
        $rose(clk2x) |=> !clk2x;
    endproperty
    a_high_one: assert property (p_high_one)
        else $error("2x clock high pulse of wrong length");

    property p_stop_bound;
        $fell(clk2x) |-> ##[1:30] $rose(clk2x);
    endproperty
    a_stop_bound: assert property (p_stop_bound)
        else $error("2x clock stopped too long");

    // a frozen clock must freeze the bus, else waits corrupt it
    property p_frozen;
        (!clk2x)[*3] |=> $stable(byte_lane_select_n) && $stable(bus_active);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("bus moved while the 2x clock was stopped");

    property p_access_ends;
        $rose(bus_active) |-> ##[2:400] $fell(bus_active);
    endproperty
    a_access_ends: assert property (p_access_ends)
        else $error("access did not complete");
endmodule // wsg_sva
`default_nettype wire

// ==== sim/tb_wait_state_clock_gate.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_wait_state_clock_gate;
    logic sys_clk = 1'h0;
    logic resetn = 1'h0;
    logic wait_req = 1'h0;
    logic acc_req = 1'h0;
    wsg_pkg::wsg_size_e acc_size = wsg_pkg::WSG_SZ_BYTE;
    logic acc_misaligned = 1'h0;
    logic acc_byte_high = 1'h0;
    logic defect_en = 1'h1;
    logic clk_held_r;
    logic stretch_overrun_r;
    logic [5:0] last_stretch_r;
    logic acc_busy_r;
    logic acc_done_r;
    int errors = 0;
    int tests_run = 0;
    int base[6] = '{1, 1, 2, 4, 6, 8};

    wsg_bus_if bus ();
    wsg_gate_end wsg_gate_end_inst (.sys_clk(sys_clk), .resetn(resetn),
        .bus(bus), .wait_req(wait_req), .clk_held_r(clk_held_r),
        .stretch_overrun_r(stretch_overrun_r),
        .last_stretch_r(last_stretch_r));
    wsg_proc_end wsg_proc_end_inst (.sys_clk(sys_clk), .resetn(resetn),
        .bus(bus), .acc_req(acc_req), .acc_size(acc_size),
        .acc_misaligned(acc_misaligned), .acc_byte_high(acc_byte_high),
        .defect_en(defect_en), .acc_busy_r(acc_busy_r),
        .acc_done_r(acc_done_r));
    wsg_sva wsg_sva_inst (.sys_clk(sys_clk), .resetn(resetn),
        .clk2x(bus.clk2x), .clk1x(bus.clk1x), .ready_n(bus.ready_n),
        .byte_lane_select_n(bus.byte_lane_select_n),
        .bus_active(bus.bus_active),
        .wait_state_cycle(bus.wait_state_cycle));

    always #20 sys_clk = ~sys_clk;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic close_out();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic give_up(input string what);
        $display("MISMATCH %0t timeout %s", $time, what);
        errors++;
        close_out();
    endtask

    // inputs move 2 ns after the edge so sampling never races
    task automatic step();
        @(posedge sys_clk);
        #2;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_free_run();
        int r2;
        int r1;
        logic p2;
        logic p1;
        r2 = 0;
        r1 = 0;
        p2 = bus.clk2x;
        p1 = bus.clk1x;
        repeat (8) begin
            step();
            if (bus.clk2x === 1'h1 && p2 === 1'h0) r2++;
            if (bus.clk1x === 1'h1 && p1 === 1'h0) r1++;
            p2 = bus.clk2x;
            p1 = bus.clk1x;
        end
        check(8'(r2), 8'h04, "2x rises");
        check(8'(r1), 8'h02, "1x rises");
    endtask

    task automatic t_stop(input int n);
        int i;
        int held;
        wait_req = 1'h1;
        for (i = 0; i < 8 && clk_held_r !== 1'h1; i++) step();
        if (clk_held_r !== 1'h1) give_up("hold");
        held = 1;
        repeat (n) begin
            check(8'(bus.clk2x), 8'h00, "2x held");
            step();
            if (clk_held_r === 1'h1) held++;
        end
        wait_req = 1'h0;
        for (i = 0; i < 12 && bus.clk2x !== 1'h1; i++) begin
            step();
            if (clk_held_r === 1'h1) held++;
        end
        if (bus.clk2x !== 1'h1) give_up("restart");
        check(8'(bus.clk1x), 8'h01, "restart phase");
        check(8'(clk_held_r), 8'h00, "held flag");
        check(8'(last_stretch_r), 8'(held), "stop length");
    endtask

    task automatic t_overrun();
        int i;
        int held;
        int lim;
        logic ok;
        wait_req = 1'h1;
        held = 0;
        lim = wsg_pkg::MAX_STOP_CYC_I;
        for (i = 0; i < 60 && stretch_overrun_r !== 1'h1; i++) begin
            step();
            if (clk_held_r === 1'h1) held++;
        end
        // the stop may run past the limit only by the resync wait
        ok = held >= lim && held <= lim + 4;
        check(8'(stretch_overrun_r), 8'h01, "overrun");
        check(8'(last_stretch_r), 8'(held), "stop length");
        check(8'(ok), 8'h01, "stop limit");
        for (i = 0; i < 8 && bus.clk2x !== 1'h1; i++) step();
        check(8'(bus.clk2x), 8'h01, "forced run");
        wait_req = 1'h0;
        repeat (4) step();
    endtask

    task automatic t_access(input int sz, input logic mis, input logic hi,
                            input logic stall);
        int i;
        int cnt;
        int exp;
        logic p2;
        logic [1:0] last;
        logic [1:0] want;
        logic [1:0] first;
        logic [1:0] want1;
        acc_size = wsg_pkg::wsg_size_e'(3'(sz));
        acc_misaligned = mis;
        acc_byte_high = hi;
        acc_req = 1'h1;
        for (i = 0; i < 20 && acc_busy_r !== 1'h1; i++) step();
        if (acc_busy_r !== 1'h1) give_up("take");
        acc_req = 1'h0;
        cnt = 0;
        last = 2'h3;
        first = 2'h3;
        p2 = bus.clk2x;
        for (i = 0; i < 400 && acc_done_r !== 1'h1; i++) begin
            // a stall mid access must not change the outcome
            wait_req = stall && i >= 1 && i < 9;
            step();
            if (acc_done_r !== 1'h1 && bus.clk2x === 1'h1 && p2 === 1'h0) cnt++;
            if (bus.byte_lane_select_n !== 2'h3) last = bus.byte_lane_select_n;
            if (first === 2'h3) first = bus.byte_lane_select_n;
            p2 = bus.clk2x;
        end
        wait_req = 1'h0;
        if (acc_done_r !== 1'h1) give_up("done");
        exp = base[sz] + ((mis && sz != 0) ? 1 : 0) + 1;
        want = (sz != 0) ? 2'h0 : (hi ? 2'h1 : 2'h2);
        check(8'(cnt), 8'(exp), "steps");
        want1 = (sz != 0) ? (mis ? 2'h1 : 2'h0) : want;
        check(8'(last), 8'(want), "lanes");
        check(8'(first), 8'(want1), "first lanes");
        step();
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        #2;
        resetn = 1'h1;
        t_free_run();
        t_stop(1);
        t_stop(10);
        t_overrun();
        t_stop(3);
        for (int s = 0; s < 6; s++) begin
            for (int m = 0; m < 2; m++) begin
                t_access(s, 1'(m), 1'h0, 1'(m));
            end
        end
        t_access(0, 1'h0, 1'h1, 1'h1);
        // second reset in mid run: link must idle, then restart clean
        resetn = 1'h0;
        step();
        check(8'(bus.clk2x), 8'h00, "reset 2x");
        check(8'(bus.byte_lane_select_n), 8'h03, "reset lanes");
        step();
        resetn = 1'h1;
        t_free_run();
        close_out();
    end
endmodule // tb_wait_state_clock_gate
`default_nettype wire
